// file: include/irq_pending_pkg.sv
// Constants and types for the interrupt request pending registers
`default_nettype none
package irq_pending_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W       = 14;
   localparam int unsigned SOURCE_COUNT = 24;
   localparam int unsigned INDEX_W      = 5;

   // Printed register indices; byte address is four times the index
   localparam logic [11:0] PEND_A_INDEX = 12'hFC0;
   localparam logic [11:0] PEND_B_INDEX = 12'hFC3;
   localparam logic [11:0] PEND_C_INDEX = 12'hFC6;
   localparam logic [13:0] PEND_A_ADDR  = {PEND_A_INDEX, 2'h0};
   localparam logic [13:0] PEND_B_ADDR  = {PEND_B_INDEX, 2'h0};
   localparam logic [13:0] PEND_C_ADDR  = {PEND_C_INDEX, 2'h0};

   // Source enables and global control
   localparam logic [13:0] ENABLE_A_ADDR = 14'h3F30;
   localparam logic [13:0] ENABLE_B_ADDR = 14'h3F34;
   localparam logic [13:0] ENABLE_C_ADDR = 14'h3F38;
   localparam logic [13:0] CONTROL_ADDR  = 14'h3F3C;
   localparam int unsigned GLOBAL_ENABLE_BIT = 0;

   // Bit positions inside the first pending register
   localparam int unsigned TIMER_ONE_BIT       = 6;
   localparam int unsigned TIMER_ZERO_BIT      = 5;
   localparam int unsigned SERIAL_RECEIVE_BIT  = 4;
   localparam int unsigned SERIAL_TRANSMIT_BIT = 3;
   localparam int unsigned CONVERTER_BIT       = 0;

   // Implemented bits of each bank; reserved bits hold zero
   localparam logic [7:0]  PEND_A_MASK = 8'h79;
   localparam logic [7:0]  PEND_B_MASK = 8'hFF;
   localparam logic [7:0]  PEND_C_MASK = 8'h0F;
   localparam logic [23:0] PEND_MASK   = {PEND_C_MASK, PEND_B_MASK, PEND_A_MASK};

   // Values after reset
   localparam logic [23:0] PEND_RESET    = 24'h000000;
   localparam logic [23:0] ENABLE_RESET  = 24'h000000;
   localparam logic        CONTROL_RESET = 1'h0;

   // Bank selects toward the pending store
   localparam logic [1:0] BANK_A = 2'h0;
   localparam logic [1:0] BANK_B = 2'h1;
   localparam logic [1:0] BANK_C = 2'h2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [2:0] {
      SEL_NONE, SEL_PEND_A, SEL_PEND_B, SEL_PEND_C,
      SEL_EN_A, SEL_EN_B, SEL_EN_C, SEL_CTRL
   } reg_sel_t;

endpackage
`default_nettype wire

// file: include/pending_if.sv
// Link between the register front end and the pending store
`timescale 1ns/1ps
`default_nettype none
interface pending_if;
   logic [23:0] hw_set;
   logic        sw_write;
   logic [1:0]  sw_bank;
   logic [7:0]  sw_data;
   logic        ack_valid;
   logic [4:0]  ack_index;
   logic [23:0] pending;

   modport store (input hw_set, sw_write, sw_bank, sw_data, ack_valid, ack_index,
                  output pending);
   modport ctrl  (output hw_set, sw_write, sw_bank, sw_data, ack_valid, ack_index,
                  input pending);
endinterface
`default_nettype wire

// file: hw/pending_store.sv
// Sticky pending bits with hardware set, software write and acknowledge clear
`timescale 1ns/1ps
`default_nettype none
module pending_store (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Front end link
   pending_if.store link
);
   typedef struct packed {
      logic [23:0] pending;
   } store_state_t;

   store_state_t cur;
   store_state_t next_state;
   logic [23:0]  set_bit;
   logic [23:0]  clr_bit;

   // Per-bit set and clear terms
   genvar i;
   generate
      for (i = 0; i < 24; i++) begin : g_bit
         logic write_hit;
         assign write_hit   = link.sw_write && (link.sw_bank == 2'(i / 8));
         assign set_bit[i]  = link.hw_set[i] || (write_hit && link.sw_data[i % 8]);
         assign clr_bit[i]  = (write_hit && !link.sw_data[i % 8])
                            || (link.ack_valid && link.ack_index == 5'(i));
      end
   endgenerate

   // Set beats clear so a coincident request survives
   always_comb begin
      next_state = cur;
      next_state.pending = ((cur.pending & ~clr_bit) | set_bit) & irq_pending_pkg::PEND_MASK;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cur.pending <= irq_pending_pkg::PEND_RESET;
      end else begin
         cur <= next_state;
      end
   end

   assign link.pending = cur.pending;
endmodule
`default_nettype wire

// file: hw/pending_regs_top.sv
// Interrupt request pending registers with AXI4-Lite access and core forwarding
//
// Summary of operation
// - Watchdog and oscillator traps stay outside.
// - Request pulse sets its sticky pending bit.
// - Global enable on: forward source-enabled pending to core.
// - Global enable off: latch anyway, software polls.
// - Read returns one while request awaits service.
// - First bank: timers, serial, converter bits.
// - Second bank: port A pins, comparator.
// - Third bank: port C pins; upper reserved.
// - Core acknowledge clears that pending bit.
// - Writing zero clears the pending bit.
// - Writing one raises the request.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pending_regs_top (
   // Clock and reset
   input  wire logic        MCLK_IN,
   input  wire logic        SRST_IN,
   // AXI4-Lite write address
   input  wire logic [13:0] AXI_AWADDR_IN,
   input  wire logic        AXI_AWVALID_IN,
   output logic             AXI_AWREADY_OUT,
   // AXI4-Lite write data
   input  wire logic [31:0] AXI_WDATA_IN,
   input  wire logic [3:0]  AXI_WSTRB_IN,
   input  wire logic        AXI_WVALID_IN,
   output logic             AXI_WREADY_OUT,
   // AXI4-Lite write response
   output logic [1:0]       AXI_BRESP_OUT,
   output logic             AXI_BVALID_OUT,
   input  wire logic        AXI_BREADY_IN,
   // AXI4-Lite read address
   input  wire logic [13:0] AXI_ARADDR_IN,
   input  wire logic        AXI_ARVALID_IN,
   output logic             AXI_ARREADY_OUT,
   // AXI4-Lite read data
   output logic [31:0]      AXI_RDATA_OUT,
   output logic [1:0]       AXI_RRESP_OUT,
   output logic             AXI_RVALID_OUT,
   input  wire logic        AXI_RREADY_IN,
   // Request pulses from on-chip sources
   input  wire logic        TIMER_ONE_REQUEST_IN,
   input  wire logic        TIMER_ZERO_REQUEST_IN,
   input  wire logic        SERIAL_RECEIVE_REQUEST_IN,
   input  wire logic        SERIAL_TRANSMIT_REQUEST_IN,
   input  wire logic        CONVERTER_REQUEST_IN,
   input  wire logic        PORT_A_PIN7_REQUEST_IN,
   input  wire logic        PORT_A_PIN6_OR_COMPARATOR_REQUEST_IN,
   input  wire logic [5:0]  PORT_A_PIN_REQUEST_IN,
   input  wire logic [3:0]  PORT_C_PIN_REQUEST_IN,
   // Core acknowledge
   input  wire logic        ACK_VALID_IN,
   input  wire logic [4:0]  ACK_INDEX_IN,
   // Toward the core
   output logic             SERVICE_REQUEST_OUT,
   output logic [23:0]      PENDING_OUT,
   output logic             GLOBAL_INTERRUPT_ENABLE_OUT
);
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        aw_held;
      logic [13:0] aw_addr;
      logic        w_held;
      logic [7:0]  w_data;
      logic        w_lane;
      logic        global_interrupt_enable;
      logic [23:0] enable;
      logic        service;
      logic [23:0] pending_copy;
   } top_state_t;

   top_state_t cur;
   top_state_t next_state;
   pending_if  link ();

   // Maps a byte address to a register; misaligned or unknown gives none
   function automatic irq_pending_pkg::reg_sel_t decode_addr(input logic [13:0] addr);
      irq_pending_pkg::reg_sel_t sel;
      sel = irq_pending_pkg::SEL_NONE;
      unique case (addr)
         irq_pending_pkg::PEND_A_ADDR:   sel = irq_pending_pkg::SEL_PEND_A;
         irq_pending_pkg::PEND_B_ADDR:   sel = irq_pending_pkg::SEL_PEND_B;
         irq_pending_pkg::PEND_C_ADDR:   sel = irq_pending_pkg::SEL_PEND_C;
         irq_pending_pkg::ENABLE_A_ADDR: sel = irq_pending_pkg::SEL_EN_A;
         irq_pending_pkg::ENABLE_B_ADDR: sel = irq_pending_pkg::SEL_EN_B;
         irq_pending_pkg::ENABLE_C_ADDR: sel = irq_pending_pkg::SEL_EN_C;
         irq_pending_pkg::CONTROL_ADDR:  sel = irq_pending_pkg::SEL_CTRL;
         default:                        sel = irq_pending_pkg::SEL_NONE;
      endcase
      return sel;
   endfunction

   // Source pulses are same-clock logic, so no synchroniser sits here
   assign link.hw_set[irq_pending_pkg::TIMER_ONE_BIT]       = TIMER_ONE_REQUEST_IN;
   assign link.hw_set[irq_pending_pkg::TIMER_ZERO_BIT]      = TIMER_ZERO_REQUEST_IN;
   assign link.hw_set[irq_pending_pkg::SERIAL_RECEIVE_BIT]  = SERIAL_RECEIVE_REQUEST_IN;
   assign link.hw_set[irq_pending_pkg::SERIAL_TRANSMIT_BIT] = SERIAL_TRANSMIT_REQUEST_IN;
   assign link.hw_set[irq_pending_pkg::CONVERTER_BIT]       = CONVERTER_REQUEST_IN;
   assign link.hw_set[7]                                    = 1'h0;
   assign link.hw_set[2:1]                                  = 2'h0;
   assign link.hw_set[15]    = PORT_A_PIN7_REQUEST_IN;
   assign link.hw_set[14]    = PORT_A_PIN6_OR_COMPARATOR_REQUEST_IN;
   assign link.hw_set[13:8]  = PORT_A_PIN_REQUEST_IN;
   assign link.hw_set[23:20] = 4'h0;
   assign link.hw_set[19:16] = PORT_C_PIN_REQUEST_IN;

   // Acknowledge goes straight to the store
   assign link.ack_valid = ACK_VALID_IN;
   assign link.ack_index = ACK_INDEX_IN;

   pending_store u_store (
      .clk_in  (MCLK_IN),
      .srst_in (SRST_IN),
      .link    (link)
   );

   // Bus slave, software writes and forwarding
   always_comb begin
      irq_pending_pkg::reg_sel_t wsel;
      irq_pending_pkg::reg_sel_t rsel;
      logic [7:0] rbyte;
      wsel          = decode_addr(cur.aw_addr);
      rsel          = decode_addr(AXI_ARADDR_IN);
      rbyte         = 8'h00;
      next_state    = cur;
      link.sw_write = 1'h0;
      link.sw_bank  = irq_pending_pkg::BANK_A;
      link.sw_data  = cur.w_data;

      // Address and data are taken independently
      if (cur.awready && AXI_AWVALID_IN) begin
         next_state.aw_held = 1'h1;
         next_state.aw_addr = AXI_AWADDR_IN;
      end
      if (cur.wready && AXI_WVALID_IN) begin
         next_state.w_held = 1'h1;
         next_state.w_data = AXI_WDATA_IN[7:0];
         next_state.w_lane = AXI_WSTRB_IN[0];
      end

      // Acknowledge drops the global enable; a same-cycle software set wins
      if (ACK_VALID_IN) begin
         next_state.global_interrupt_enable = 1'h0;
      end

      // Both halves present: perform the write and answer
      if (cur.aw_held && cur.w_held && !cur.bvalid) begin
         next_state.aw_held = 1'h0;
         next_state.w_held  = 1'h0;
         next_state.bvalid  = 1'h1;
         next_state.bresp   = (wsel == irq_pending_pkg::SEL_NONE) ?
                              irq_pending_pkg::RESP_DECERR : irq_pending_pkg::RESP_OKAY;
         if (cur.w_lane) begin
            unique case (wsel)
               irq_pending_pkg::SEL_PEND_A: begin
                  link.sw_write = 1'h1;
                  link.sw_bank  = irq_pending_pkg::BANK_A;
               end
               irq_pending_pkg::SEL_PEND_B: begin
                  link.sw_write = 1'h1;
                  link.sw_bank  = irq_pending_pkg::BANK_B;
               end
               irq_pending_pkg::SEL_PEND_C: begin
                  link.sw_write = 1'h1;
                  link.sw_bank  = irq_pending_pkg::BANK_C;
               end
               irq_pending_pkg::SEL_EN_A: begin
                  next_state.enable[7:0] = cur.w_data & irq_pending_pkg::PEND_A_MASK;
               end
               irq_pending_pkg::SEL_EN_B: begin
                  next_state.enable[15:8] = cur.w_data & irq_pending_pkg::PEND_B_MASK;
               end
               irq_pending_pkg::SEL_EN_C: begin
                  next_state.enable[23:16] = cur.w_data & irq_pending_pkg::PEND_C_MASK;
               end
               irq_pending_pkg::SEL_CTRL: begin
                  next_state.global_interrupt_enable =
                     cur.w_data[irq_pending_pkg::GLOBAL_ENABLE_BIT];
               end
               irq_pending_pkg::SEL_NONE: begin
               end
            endcase
         end
      end
      if (cur.bvalid && AXI_BREADY_IN) begin
         next_state.bvalid = 1'h0;
      end

      // Read path; pending reads show the live sticky bits
      unique case (rsel)
         irq_pending_pkg::SEL_PEND_A: rbyte = link.pending[7:0];
         irq_pending_pkg::SEL_PEND_B: rbyte = link.pending[15:8];
         irq_pending_pkg::SEL_PEND_C: rbyte = link.pending[23:16];
         irq_pending_pkg::SEL_EN_A:   rbyte = cur.enable[7:0];
         irq_pending_pkg::SEL_EN_B:   rbyte = cur.enable[15:8];
         irq_pending_pkg::SEL_EN_C:   rbyte = cur.enable[23:16];
         irq_pending_pkg::SEL_CTRL:   rbyte = {7'h00, cur.global_interrupt_enable};
         irq_pending_pkg::SEL_NONE:   rbyte = 8'h00;
      endcase
      if (cur.arready && AXI_ARVALID_IN) begin
         next_state.rvalid = 1'h1;
         next_state.rdata  = {24'h000000, rbyte};
         next_state.rresp  = (rsel == irq_pending_pkg::SEL_NONE) ?
                             irq_pending_pkg::RESP_DECERR : irq_pending_pkg::RESP_OKAY;
      end
      if (cur.rvalid && AXI_RREADY_IN) begin
         next_state.rvalid = 1'h0;
      end

      // One write and one read in flight; ready stays low until answered
      next_state.awready = !next_state.aw_held && !next_state.bvalid;
      next_state.wready  = !next_state.w_held && !next_state.bvalid;
      next_state.arready = !next_state.rvalid;

      // Vectored forwarding only while globally enabled
      next_state.service      = cur.global_interrupt_enable
                              && |(link.pending & cur.enable);
      next_state.pending_copy = link.pending;
   end

   // Synchronous reset; ready outputs rise one edge after release
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         cur <= '0;
         cur.enable                  <= irq_pending_pkg::ENABLE_RESET;
         cur.global_interrupt_enable <= irq_pending_pkg::CONTROL_RESET;
         cur.pending_copy            <= irq_pending_pkg::PEND_RESET;
      end else begin
         cur <= next_state;
      end
   end

   // Outputs straight from flops
   assign AXI_AWREADY_OUT             = cur.awready;
   assign AXI_WREADY_OUT              = cur.wready;
   assign AXI_BVALID_OUT              = cur.bvalid;
   assign AXI_BRESP_OUT               = cur.bresp;
   assign AXI_ARREADY_OUT             = cur.arready;
   assign AXI_RVALID_OUT              = cur.rvalid;
   assign AXI_RRESP_OUT               = cur.rresp;
   assign AXI_RDATA_OUT               = cur.rdata;
   assign SERVICE_REQUEST_OUT         = cur.service;
   assign PENDING_OUT                 = cur.pending_copy;
   assign GLOBAL_INTERRUPT_ENABLE_OUT = cur.global_interrupt_enable;
endmodule
`default_nettype wire

// file: bench/irq_pending_sva.sv
// Assertion checker for the pending register block
`timescale 1ns/1ps
`default_nettype none
module irq_pending_sva (
   input wire logic        MCLK_IN,
   input wire logic        SRST_IN,
   input wire logic        AXI_ARVALID_IN,
   input wire logic        AXI_ARREADY_OUT,
   input wire logic        AXI_RVALID_OUT,
   input wire logic [31:0] AXI_RDATA_OUT,
   input wire logic        AXI_BVALID_OUT,
   input wire logic        TIMER_ONE_REQUEST_IN,
   input wire logic        TIMER_ZERO_REQUEST_IN,
   input wire logic        SERIAL_RECEIVE_REQUEST_IN,
   input wire logic        SERIAL_TRANSMIT_REQUEST_IN,
   input wire logic        CONVERTER_REQUEST_IN,
   input wire logic        PORT_A_PIN7_REQUEST_IN,
   input wire logic        PORT_A_PIN6_OR_COMPARATOR_REQUEST_IN,
   input wire logic [5:0]  PORT_A_PIN_REQUEST_IN,
   input wire logic [3:0]  PORT_C_PIN_REQUEST_IN,
   input wire logic        ACK_VALID_IN,
   input wire logic [4:0]  ACK_INDEX_IN,
   input wire logic        SERVICE_REQUEST_OUT,
   input wire logic [23:0] PENDING_OUT,
   input wire logic        GLOBAL_INTERRUPT_ENABLE_OUT
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (SRST_IN);
   logic [23:0] req_vec;
   // Request pins gathered in pending bit order
   assign req_vec = {4'h0, PORT_C_PIN_REQUEST_IN, PORT_A_PIN7_REQUEST_IN,
      PORT_A_PIN6_OR_COMPARATOR_REQUEST_IN, PORT_A_PIN_REQUEST_IN, 1'b0,
      TIMER_ONE_REQUEST_IN, TIMER_ZERO_REQUEST_IN, SERIAL_RECEIVE_REQUEST_IN,
      SERIAL_TRANSMIT_REQUEST_IN, 2'h0, CONVERTER_REQUEST_IN};
   // Store edge, then the copy edge toward the core
   sequence s_store_copy;
      ##2 1'b1;
   endsequence
   sequence s_ack_alone;
      ACK_VALID_IN && ACK_INDEX_IN < 5'h18 && req_vec == 24'h0;
   endsequence
   property p_req_sets;
      req_vec != 24'h0 |-> s_store_copy ##0
         ((PENDING_OUT & $past(req_vec, 2)) == $past(req_vec, 2));
   endproperty
   property p_ack_clears;
      s_ack_alone |-> s_store_copy ##0 !PENDING_OUT[$past(ACK_INDEX_IN, 2)];
   endproperty
   property p_ack_drops_gie;
      ACK_VALID_IN |-> ##[1:2] !GLOBAL_INTERRUPT_ENABLE_OUT;
   endproperty
   property p_polled_quiet;
      !GLOBAL_INTERRUPT_ENABLE_OUT [*3] |-> !SERVICE_REQUEST_OUT;
   endproperty
   property p_reset_clear;
      $fell(SRST_IN) |-> PENDING_OUT == 24'h0 && !SERVICE_REQUEST_OUT;
   endproperty
   property p_reserved_zero;
      (PENDING_OUT & ~irq_pending_pkg::PEND_MASK) == 24'h0;
   endproperty
   property p_read_answer;
      AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT && AXI_RDATA_OUT[31:8] == 24'h0;
   endproperty
   // A bit may only drop after an acknowledge, a completed write or a reset;
   // the release edge itself is not disabled, so reset must be allowed here
   property p_no_stray_clear;
      ($past(PENDING_OUT) & ~PENDING_OUT) != 24'h0 |->
         $past(ACK_VALID_IN, 2) || $past(AXI_BVALID_OUT) || $past(SRST_IN);
   endproperty
   a_req_sets: assert property (p_req_sets) else $error("request not latched");
   a_ack_clears: assert property (p_ack_clears) else $error("ack left bit set");
   a_ack_drops_gie: assert property (p_ack_drops_gie) else $error("enable kept");
   a_polled_quiet: assert property (p_polled_quiet) else $error("service in polled");
   a_reset_clear: assert property (p_reset_clear) else $error("reset left state");
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");
   a_read_answer: assert property (p_read_answer) else $error("bad read answer");
   a_no_stray_clear: assert property (p_no_stray_clear) else $error("bit lost");
endmodule
bind pending_regs_top irq_pending_sva chk_u (.*);
`default_nettype wire

// file: bench/core_ack_model.sv
// Behavioural processor core that acknowledges service requests
`timescale 1ns/1ps
`default_nettype none
module core_ack_model #(
   parameter int GAP = 4
) (
   input wire logic        clk_in,
   input wire logic        srst_in,
   input wire logic        ack_en_in,
   input wire logic        service_in,
   input wire logic [23:0] pending_in,
   output logic            ack_valid_out,
   output logic [4:0]      ack_index_out
);
   int          gap_cnt;
   logic [4:0]  pick;
   // Lowest pending bit wins; real priority lives elsewhere
   always_comb begin
      pick = 5'h1F;
      for (int i = 23; i >= 0; i--) begin
         if (pending_in[i]) pick = i[4:0];
      end
   end
   // One-cycle acknowledge, then a quiet gap so the copy can settle
   always @(posedge clk_in) begin
      ack_valid_out <= 1'b0;
      ack_index_out <= ~ack_index_out;  // Stale index never holds still
      if (srst_in) begin
         gap_cnt <= 0;
         ack_index_out <= 5'h00;
      end else if (gap_cnt > 0) begin
         gap_cnt <= gap_cnt - 1;
      end else if (ack_en_in && service_in && pending_in != 24'h0) begin
         ack_valid_out <= 1'b1;
         ack_index_out <= pick;
         gap_cnt <= GAP;
      end
   end
endmodule
`default_nettype wire

// file: bench/interrupt_request_pending_regs_bench.sv
// Self-checking bench for the interrupt pending registers
`timescale 1ns/1ps
`default_nettype none
module interrupt_request_pending_regs_bench;
   localparam logic [1:0] OK = irq_pending_pkg::RESP_OKAY;
   localparam logic [1:0] DE = irq_pending_pkg::RESP_DECERR;
   localparam logic [2:0][13:0] BANK = {irq_pending_pkg::PEND_C_ADDR,
      irq_pending_pkg::PEND_B_ADDR, irq_pending_pkg::PEND_A_ADDR};
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
   logic [31:0] wdata = 32'h0;
   logic [23:0] req = 24'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, ack_en = 1'b0;
   logic [3:0]  wstrb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid, service, gie, ack_v;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [23:0] pend;
   logic [4:0]  ack_i;
   int          n_fail = 0;
   int          num_checks = 0;

   // 25 MHz system clock
   always #20 clk = ~clk;

   pending_regs_top dut_u (
      .MCLK_IN(clk), .SRST_IN(srst), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
      .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
      .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
      .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
      .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
      .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
      .TIMER_ONE_REQUEST_IN(req[6]), .TIMER_ZERO_REQUEST_IN(req[5]),
      .SERIAL_RECEIVE_REQUEST_IN(req[4]), .SERIAL_TRANSMIT_REQUEST_IN(req[3]),
      .CONVERTER_REQUEST_IN(req[0]), .PORT_A_PIN7_REQUEST_IN(req[15]),
      .PORT_A_PIN6_OR_COMPARATOR_REQUEST_IN(req[14]), .PORT_A_PIN_REQUEST_IN(req[13:8]),
      .PORT_C_PIN_REQUEST_IN(req[19:16]), .ACK_VALID_IN(ack_v), .ACK_INDEX_IN(ack_i),
      .SERVICE_REQUEST_OUT(service), .PENDING_OUT(pend), .GLOBAL_INTERRUPT_ENABLE_OUT(gie)
   );
   core_ack_model #(.GAP(4)) core_u (
      .clk_in(clk), .srst_in(srst), .ack_en_in(ack_en), .service_in(service),
      .pending_in(pend), .ack_valid_out(ack_v), .ack_index_out(ack_i)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // A wait that ran out is a mismatch and ends the run
   task automatic give_up;
      chk(32'h0, 32'h1);
      tally_and_finish();
   endtask
   // One-cycle request pulse, as the sources give it
   task automatic pulse(input logic [23:0] p);
      @(posedge clk);
      req <= p;
      @(posedge clk);
      req <= 24'h0;
   endtask
   // Write; p pulses requests in the cycle the write lands
   task automatic bus_write(input logic [13:0] a, input logic [7:0] d,
                            input logic [23:0] p, input logic [1:0] er);
      bit aw = 0;
      bit w = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int n = 0; n < 30 && !(aw && w); n++) begin
         @(posedge clk);
         aw |= awready;
         w |= wready;
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      if (!(aw && w)) give_up();
      req <= p;
      bready <= 1'b1;
      for (int n = 0; n < 30; n++) begin
         @(posedge clk);
         req <= 24'h0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
      if (bvalid !== 1'b1) give_up();
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic bus_read(input logic [13:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 30; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rready <= 1'b0;
      if (rvalid !== 1'b1) give_up();
      chk(rdata, {24'h0, e});
      chk({30'h0, rresp}, {30'h0, er});
   endtask

   task automatic t_reset;
      for (int b = 0; b < 3; b++) bus_read(BANK[b], 8'h00, OK);
      bus_read(irq_pending_pkg::CONTROL_ADDR, 8'h00, OK);
      bus_read(14'h0004, 8'h00, DE);
      bus_write(14'h0004, 8'hFF, 24'h0, DE);
      // Low byte lane off: answered but nothing stored
      wstrb <= 4'h0;
      bus_write(BANK[0], 8'hFF, 24'h0, OK);
      wstrb <= 4'hF;
      bus_read(BANK[0], 8'h00, OK);
   endtask
   // Every source alone, read back, then cleared by a zero write
   task automatic t_map;
      for (int i = 0; i < 24; i++) begin
         if (irq_pending_pkg::PEND_MASK[i]) begin
            pulse(24'h1 << i);
            bus_read(BANK[i / 8], 8'h01 << (i % 8), OK);
            chk({8'h0, pend}, 32'h1 << i);
            bus_write(BANK[i / 8], 8'h00, 24'h0, OK);
            bus_read(BANK[i / 8], 8'h00, OK);
         end
      end
   endtask
   task automatic t_sw_set;
      for (int b = 0; b < 3; b++) begin
         bus_write(BANK[b], 8'hFF, 24'h0, OK);
         bus_read(BANK[b], irq_pending_pkg::PEND_MASK[b * 8 +: 8], OK);
         bus_write(BANK[b], 8'h00, 24'h0, OK);
         bus_read(BANK[b], 8'h00, OK);
      end
   endtask
   // Clearing write and timer pulse land together
   task automatic t_set_wins;
      bus_write(BANK[0], 8'h21, 24'h0, OK);
      bus_write(BANK[0], 8'h00, 24'h20, OK);
      bus_read(BANK[0], 8'h20, OK);
      bus_write(BANK[0], 8'h00, 24'h0, OK);
   endtask
   task automatic t_vectored;
      bus_write(irq_pending_pkg::ENABLE_A_ADDR, 8'h40, 24'h0, OK);
      bus_write(irq_pending_pkg::CONTROL_ADDR, 8'h01, 24'h0, OK);
      chk({31'h0, gie}, 32'h1);
      ack_en <= 1'b1;
      pulse(24'h40);
      for (int n = 0; n < 20; n++) begin
         @(posedge clk);
         if (ack_v === 1'b1) break;
      end
      if (ack_v !== 1'b1) give_up();
      chk({27'h0, ack_i}, 32'h6);
      bus_read(BANK[0], 8'h00, OK);
      bus_read(irq_pending_pkg::CONTROL_ADDR, 8'h00, OK);
      chk({31'h0, gie}, 32'h0);
      pulse(24'h40);
      repeat (4) @(posedge clk);
      chk({31'h0, service}, 32'h0);
      bus_read(BANK[0], 8'h40, OK);
      ack_en <= 1'b0;
      bus_write(BANK[0], 8'h00, 24'h0, OK);
   endtask

   // Mid-run reset with state held; pending bits and global enable come back clear
   task automatic t_mid_reset;
      bus_write(BANK[1], 8'hFF, 24'h0, OK);
      bus_write(irq_pending_pkg::CONTROL_ADDR, 8'h01, 24'h0, OK);
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      chk({8'h0, pend}, 32'h0);
      chk({31'h0, gie}, 32'h0);
      for (int b = 0; b < 3; b++) bus_read(BANK[b], 8'h00, OK);
   endtask

   // Reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_map();
      t_sw_set();
      t_set_wins();
      t_vectored();
      t_mid_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
